// >>> rtl/sss_params.svh
// Constants of the safe state supervisor: offsets, fields, resets, timing.
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SSS_ADDR_CTRL 8'h00
`define SSS_ADDR_STATUS 8'h04

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SSS_CTRL_APP_SAFE 0
`define SSS_STAT_STATE 0
`define SSS_STAT_SUPPLY_WARN 3
`define SSS_STAT_STARTUP_OK 4
`define SSS_STAT_TUNE_EN 5
`define SSS_STAT_FAIL_NOW 6
`define SSS_STAT_WD_EXPIRED 8

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define SSS_CTRL_RESET 1'b0
`define SSS_CRC_INIT 8'h00
`define SSS_CRC_POLY 8'h07
`define SSS_CLK_MHZ 40
`define SSS_WD_TIMEOUT_US 10000
`define SSS_WD_CYCLES (`SSS_WD_TIMEOUT_US * `SSS_CLK_MHZ)

`endif

// >>> rtl/sss_pkg.sv
// Types shared by the safe state supervisor.
package sss_pkg;

   // Supervisor states, one-hot.
   typedef enum logic [2:0] {
      ST_STARTUP = 3'b001,
      ST_SAFE = 3'b010,
      ST_RUN = 3'b100
   } sss_state_type;

endpackage : sss_pkg

// >>> rtl/sss_supervisor.sv
// Safe state supervisor: trip latch, input substitution, port gating.
`timescale 1ns/100ps
`include "sss_params.svh"

module sss_supervisor
   import sss_pkg::*;
#(
   parameter int N_DI = 8,
   parameter int N_AI = 4,
   parameter int N_DO = 8,
   parameter int N_AO = 2,
   parameter int AW = 16,
   parameter int N_MOD = 4,
   parameter int WDW = 20,
   parameter int WD_CYCLES = `SSS_WD_CYCLES
) (
   input wire logic i_clock, // System clock, 40 MHz.
   input wire logic i_rstn, // Asynchronous reset, active low.
   input wire logic [1:0] i_supply_ok, // Supply unit healthy, one bit each.
   input wire logic i_fault_class1, // Most severe fault class present.
   input wire logic i_fault_class2, // Second severe fault class present.
   input wire logic i_selftest_done, // Startup self-tests finished.
   input wire logic i_selftest_pass, // Startup self-tests passed.
   input wire logic i_config_ok, // Configuration check consistent.
   input wire logic [N_MOD-1:0] i_module_type_ok, // Slot holds right type.
   input wire logic i_diag_safe_demand, // Platform diagnostics demand trip.
   input wire logic i_override_key, // Manual safety override set.
   input wire logic i_release, // Human release button.
   input wire logic i_tune_key, // Keyswitch in parameter-adjust mode.
   input wire logic [N_MOD-1:0] i_wd_kick, // Module alive pulses.
   input wire logic [N_DI-1:0] i_di_raw, // Discrete input values.
   input wire logic [N_DI-1:0] i_di_fault, // Discrete channel faulted.
   input wire logic [N_AI*AW-1:0] i_ai_raw, // Analog input values.
   input wire logic [N_AI-1:0] i_ai_fault, // Analog channel faulted.
   input wire logic [N_DO-1:0] i_app_do, // Application discrete outputs.
   input wire logic [N_AO*AW-1:0] i_app_ao, // Application analog outputs.
   input wire logic i_tune_valid, // Inward tuning byte present.
   input wire logic [7:0] i_tune_data, // Inward tuning byte.
   input wire logic i_tune_last, // Byte is the frame check byte.
   input wire logic [7:0] i_addr, // Register byte address.
   input wire logic [31:0] i_wdata, // Register write data.
   input wire logic i_we, // Register write strobe.
   input wire logic i_re, // Register read strobe.
   output logic [31:0] o_rdata, // Read data, one cycle after strobe.
   output logic [N_DI-1:0] o_di_value, // Discrete inputs after faulting.
   output logic [N_AI*AW-1:0] o_ai_value, // Analog inputs after faulting.
   output logic [N_DO-1:0] o_do_energize, // Field discrete outputs.
   output logic [N_AO*AW-1:0] o_ao_value, // Field analog outputs.
   output logic o_safe, // Outputs held in safe state.
   output logic o_supply_warn, // Redundant supply lost, sticky.
   output logic o_tune_port_en, // Tuning port active.
   output logic o_tune_valid, // Accepted tuning byte.
   output logic [7:0] o_tune_data, // Accepted tuning byte value.
   output logic o_tune_good, // Frame check matched, pulse.
   output logic o_tune_bad, // Frame check failed, pulse.
   output logic o_tune_reject, // Inward byte refused, pulse.
   output logic [7:0] o_mon_status // One-way monitoring broadcast.
);

   // ----------------------------------------------------------------------
   // State record
   // ----------------------------------------------------------------------
   typedef struct packed {
      sss_state_type st;
      logic rel_prev;
      logic app_safe_req;
      logic supply_warn;
      logic [N_MOD-1:0][WDW-1:0] wd_cnt;
      logic [7:0] crc;
      logic [N_DI-1:0] di_out;
      logic [N_AI*AW-1:0] ai_out;
      logic [N_DO-1:0] do_out;
      logic [N_AO*AW-1:0] ao_out;
      logic safe;
      logic tune_en;
      logic tune_valid;
      logic [7:0] tune_data;
      logic tune_good;
      logic tune_bad;
      logic tune_reject;
      logic [31:0] rdata;
      logic [7:0] mon;
   } sss_reg_type;

   sss_reg_type r_q;
   sss_reg_type r_d;

   logic power_lost;
   logic startup_ok;
   logic [N_MOD-1:0] wd_expired;
   logic fail_now;
   logic rel_edge;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------

   // One byte of CRC-8, MSB first; used for every inward frame through an open port.
   function automatic logic [7:0] crc8_byte(input logic [7:0] crc,
                                            input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int b = 0; b < 8; b++) begin
         if (c[7]) begin
            c = {c[6:0], 1'b0} ^ `SSS_CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction : crc8_byte

   // ----------------------------------------------------------------------
   // Failure conditions
   // ----------------------------------------------------------------------

   // Each module has its own watchdog; a saturated counter is an expiry.
   for (genvar m = 0; m < N_MOD; m++) begin : g_wd
      assign wd_expired[m] = (r_q.wd_cnt[m] == WDW'(WD_CYCLES));
   end

   // Both supplies gone means power is off.
   assign power_lost = (i_supply_ok == 2'b00);
   // Self-tests, configuration and module types all gate startup.
   assign startup_ok = i_selftest_done & i_selftest_pass & i_config_ok &
                       (&i_module_type_ok);
   // Anything that would trip also blocks a release.
   assign fail_now = power_lost | i_fault_class1 | i_fault_class2 |
                     i_diag_safe_demand | r_q.app_safe_req |
                     i_override_key | i_tune_key | (|wd_expired) |
                     ~startup_ok;
   // Edge only, so a button held across a trip cannot re-release.
   assign rel_edge = i_release & ~r_q.rel_prev;

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------

   // All next values; outputs follow the next supervisor state.
   always_comb begin
      r_d = r_q;
      r_d.rel_prev = i_release;
      r_d.tune_valid = 1'b0;
      r_d.tune_good = 1'b0;
      r_d.tune_bad = 1'b0;
      r_d.tune_reject = 1'b0;

      // Supervisor: any failure drops into a latched safe state.
      case (r_q.st)
         ST_STARTUP: begin
            if (startup_ok && !fail_now) begin
               r_d.st = ST_SAFE;
            end
         end
         ST_SAFE: begin
            if (rel_edge && !fail_now) begin
               r_d.st = ST_RUN;
            end
         end
         ST_RUN: begin
            if (fail_now) begin
               r_d.st = ST_SAFE;
            end
         end
         default: begin
            r_d.st = ST_STARTUP;
         end
      endcase
      if (power_lost) begin
         r_d.st = ST_STARTUP;
      end

      // Watchdog counters restart on a kick and saturate at expiry.
      for (int m = 0; m < N_MOD; m++) begin
         if (i_wd_kick[m]) begin
            r_d.wd_cnt[m] = '0;
         end else if (!wd_expired[m]) begin
            r_d.wd_cnt[m] = r_q.wd_cnt[m] + WDW'(1);
         end
      end

      // A single supply lost is only flagged; set wins over clear.
      if (i_we && i_addr == `SSS_ADDR_STATUS &&
          i_wdata[`SSS_STAT_SUPPLY_WARN]) begin
         r_d.supply_warn = 1'b0;
      end
      if (^i_supply_ok) begin
         r_d.supply_warn = 1'b1;
      end

      // Register writes.
      if (i_we && i_addr == `SSS_ADDR_CTRL) begin
         r_d.app_safe_req = i_wdata[`SSS_CTRL_APP_SAFE];
      end

      // Register reads, answered in the next cycle; unmapped reads zero.
      r_d.rdata = 32'h0;
      if (i_re && i_addr == `SSS_ADDR_CTRL) begin
         r_d.rdata[`SSS_CTRL_APP_SAFE] = r_q.app_safe_req;
      end else if (i_re && i_addr == `SSS_ADDR_STATUS) begin
         r_d.rdata[`SSS_STAT_STATE +: 3] = r_q.st;
         r_d.rdata[`SSS_STAT_SUPPLY_WARN] = r_q.supply_warn;
         r_d.rdata[`SSS_STAT_STARTUP_OK] = startup_ok;
         r_d.rdata[`SSS_STAT_TUNE_EN] = r_q.tune_en;
         r_d.rdata[`SSS_STAT_FAIL_NOW] = fail_now;
         r_d.rdata[`SSS_STAT_WD_EXPIRED +: N_MOD] = wd_expired;
      end

      // Faulted channels read as open contact or zero level.
      for (int i = 0; i < N_DI; i++) begin
         r_d.di_out[i] = i_di_raw[i] & ~i_di_fault[i];
      end
      for (int i = 0; i < N_AI; i++) begin
         r_d.ai_out[i*AW +: AW] = i_ai_fault[i] ? '0 :
                                  i_ai_raw[i*AW +: AW];
      end

      // Field outputs pass only in run, never while tuning or overridden.
      if (r_d.st == ST_RUN && !i_tune_key && !i_override_key) begin
         r_d.do_out = i_app_do;
         r_d.ao_out = i_app_ao;
         r_d.safe = 1'b0;
      end else begin
         r_d.do_out = '0;
         r_d.ao_out = '0;
         r_d.safe = 1'b1;
      end

      // Tuning port: open only in parameter-adjust mode, frames checked.
      r_d.tune_en = i_tune_key;
      if (i_tune_valid && !r_q.tune_en) begin
         r_d.tune_reject = 1'b1;
         r_d.crc = `SSS_CRC_INIT;
      end else if (i_tune_valid && i_tune_last) begin
         r_d.tune_good = (r_q.crc == i_tune_data);
         r_d.tune_bad = (r_q.crc != i_tune_data);
         r_d.crc = `SSS_CRC_INIT;
      end else if (i_tune_valid) begin
         r_d.tune_valid = 1'b1;
         r_d.tune_data = i_tune_data;
         r_d.crc = crc8_byte(r_q.crc, i_tune_data);
      end
      if (!i_tune_key) begin
         r_d.crc = `SSS_CRC_INIT;
      end

      // Broadcast status; no input path reaches back from the station.
      r_d.mon = {power_lost, startup_ok, r_d.tune_en, (|wd_expired),
                 r_d.supply_warn, r_d.st};
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------

   // Reset lands in startup with every field output de-energized and o_safe high.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         r_q <= '0;
         r_q.st <= ST_STARTUP;
         r_q.app_safe_req <= `SSS_CTRL_RESET;
         r_q.crc <= `SSS_CRC_INIT;
         r_q.safe <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   // Outputs come straight from the record.
   assign o_rdata = r_q.rdata;
   assign o_di_value = r_q.di_out;
   assign o_ai_value = r_q.ai_out;
   assign o_do_energize = r_q.do_out;
   assign o_ao_value = r_q.ao_out;
   assign o_safe = r_q.safe;
   assign o_supply_warn = r_q.supply_warn;
   assign o_tune_port_en = r_q.tune_en;
   assign o_tune_valid = r_q.tune_valid;
   assign o_tune_data = r_q.tune_data;
   assign o_tune_good = r_q.tune_good;
   assign o_tune_bad = r_q.tune_bad;
   assign o_tune_reject = r_q.tune_reject;
   assign o_mon_status = r_q.mon;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------

   // Not running means nothing energized in the field.
   a_out_safe_idle: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      (r_q.st != ST_RUN) |-> (o_do_energize == '0 && o_ao_value == '0))
      else $error("output energized outside run");

   // Total supply loss leaves run within one cycle.
   a_power_loss_trip: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      (i_supply_ok == 2'b00) |=> (r_q.st == ST_STARTUP && o_safe))
      else $error("supply loss did not trip");

   // Single supply loss flags without tripping.
   a_supply_warn_set: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      (^i_supply_ok && r_q.st == ST_RUN && !fail_now) |=>
      (o_supply_warn && r_q.st == ST_RUN))
      else $error("redundant supply loss mishandled");

   // The warning stays up until software writes a one to clear it.
   a_warn_sticky: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      (o_supply_warn && !(i_we && i_addr == `SSS_ADDR_STATUS &&
      i_wdata[`SSS_STAT_SUPPLY_WARN])) |=> o_supply_warn)
      else $error("supply warning dropped without a clear");

   // Startup holds until every check passes.
   a_startup_hold: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      (r_q.st == ST_STARTUP && !startup_ok) |=> (r_q.st == ST_STARTUP))
      else $error("left startup with failed checks");

   // Failed module or configuration checks never let the outputs run.
   a_checks_gate_run: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      !startup_ok |=> (r_q.st != ST_RUN && o_safe))
      else $error("outputs ran with failed startup checks");

   // Override always yields de-energized outputs next cycle.
   a_override_trip: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      i_override_key |=> (o_do_energize == '0 && o_safe))
      else $error("override did not force safe");

   // A clean release edge in safe moves to run.
   a_release_edge: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      (r_q.st == ST_SAFE && i_release && !r_q.rel_prev && !fail_now) |=>
      (r_q.st == ST_RUN))
      else $error("release edge ignored");

   // A held release never leaves safe.
   a_release_held: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      (r_q.st == ST_SAFE && r_q.rel_prev) |=> (r_q.st != ST_RUN))
      else $error("held release left safe state");

   // Without any release the safe state never lets go.
   a_safe_needs_release: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      (r_q.st != ST_RUN && !i_release) |=> (r_q.st != ST_RUN))
      else $error("safe state left without release");

   // A run trip stays latched without a release; power loss restarts.
   a_trip_latched: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      (r_q.st == ST_RUN && fail_now && !power_lost) ##1
      (!i_release && !power_lost) |=> (r_q.st == ST_SAFE))
      else $error("trip did not latch");

   // Watchdog expiry drops run.
   a_wd_expiry_trip: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      (r_q.st == ST_RUN && (|wd_expired)) |=> (r_q.st != ST_RUN))
      else $error("watchdog expiry did not trip");

   // Tuning keeps every field output de-energized.
   a_tune_isolate: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      o_tune_port_en |->
      (o_do_energize == '0 && o_ao_value == '0 && o_safe))
      else $error("field output live while tuning");

   // Inward byte outside tuning mode is refused.
   a_tune_reject: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      (i_tune_valid && !o_tune_port_en) |=> (o_tune_reject && !o_tune_valid))
      else $error("inward byte accepted while blocked");

   // Data passes to the tuning side only through a port already open.
   a_tune_accept_gate: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      o_tune_valid |-> $past(o_tune_port_en))
      else $error("tuning byte passed a closed port");

   // Faulted channels never read high.
   a_fault_subst: assert property (@(posedge i_clock)
      disable iff (!i_rstn)
      ##1 ((o_di_value & $past(i_di_fault)) == '0))
      else $error("faulted input not substituted");

endmodule : sss_supervisor

// >>> testbench/sss_io_model.sv
// Chassis input and output module stand-in: per-module watchdog kicks.
`timescale 1ns/100ps
module sss_io_model #(
   parameter int N_MOD = 4
) (
   input wire logic i_clock, // System clock.
   input wire logic i_rstn, // Reset, active low.
   input wire logic i_kick_en, // Modules alive.
   output logic [N_MOD-1:0] o_wd_kick // Alive pulses, one per module.
);
   logic [2:0] cnt_q;
   // -------------------------------------------------------------------
   // Kick generator
   // -------------------------------------------------------------------
   // Each module kicks once in eight cycles, staggered so no two coincide.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_q <= 3'h0;
         o_wd_kick <= '0;
      end else begin
         cnt_q <= cnt_q + 3'h1;
         for (int m = 0; m < N_MOD; m++) begin
            o_wd_kick[m] <= i_kick_en && (cnt_q == 3'(m));
         end
      end
   end
endmodule : sss_io_model

// >>> testbench/tb_top.sv
// Self-checking bench for the safe state supervisor.
`timescale 1ns/100ps
`include "sss_params.svh"
module tb_top;
   import sss_pkg::*;
   localparam int WDC = 50;
   logic i_clock = 1'b0;
   logic i_rstn = 1'b0;
   logic [1:0] i_supply_ok = 2'b11;
   logic i_fault_class1 = 1'b0;
   logic i_fault_class2 = 1'b0;
   logic i_selftest_done = 1'b0;
   logic i_selftest_pass = 1'b0;
   logic i_config_ok = 1'b0;
   logic [3:0] i_module_type_ok = 4'he;
   logic i_diag_safe_demand = 1'b0;
   logic i_override_key = 1'b0;
   logic i_release = 1'b0;
   logic i_tune_key = 1'b0;
   logic kick_en = 1'b1;
   logic [3:0] i_wd_kick;
   logic [7:0] i_di_raw = 8'h00;
   logic [7:0] i_di_fault = 8'h00;
   logic [63:0] i_ai_raw = 64'h0;
   logic [3:0] i_ai_fault = 4'h0;
   logic [7:0] i_app_do = 8'h00;
   logic [31:0] i_app_ao = 32'h0;
   logic i_tune_valid = 1'b0;
   logic [7:0] i_tune_data = 8'h00;
   logic i_tune_last = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic i_we = 1'b0;
   logic i_re = 1'b0;
   logic [31:0] o_rdata, d, seed = 32'h0e45312a;
   logic [7:0] o_di_value, o_do_energize, o_tune_data, o_mon_status, b;
   logic [63:0] o_ai_value;
   logic [31:0] o_ao_value;
   logic o_safe, o_supply_warn, o_tune_port_en, o_tune_valid;
   logic o_tune_good, o_tune_bad, o_tune_reject;
   int miscompares = 0;
   int n_tests = 0;
   int exp_run = 0;
   // -------------------------------------------------------------------
   // Design, partner and clock
   // -------------------------------------------------------------------
   sss_supervisor #(.WD_CYCLES(WDC)) sss_supervisor_i (.i_clock(i_clock),
      .i_rstn(i_rstn), .i_supply_ok(i_supply_ok),
      .i_fault_class1(i_fault_class1), .i_fault_class2(i_fault_class2),
      .i_selftest_done(i_selftest_done), .i_selftest_pass(i_selftest_pass),
      .i_config_ok(i_config_ok), .i_module_type_ok(i_module_type_ok),
      .i_diag_safe_demand(i_diag_safe_demand),
      .i_override_key(i_override_key), .i_release(i_release),
      .i_tune_key(i_tune_key), .i_wd_kick(i_wd_kick), .i_di_raw(i_di_raw),
      .i_di_fault(i_di_fault), .i_ai_raw(i_ai_raw), .i_ai_fault(i_ai_fault),
      .i_app_do(i_app_do), .i_app_ao(i_app_ao),
      .i_tune_valid(i_tune_valid), .i_tune_data(i_tune_data),
      .i_tune_last(i_tune_last), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata),
      .o_di_value(o_di_value), .o_ai_value(o_ai_value),
      .o_do_energize(o_do_energize), .o_ao_value(o_ao_value),
      .o_safe(o_safe), .o_supply_warn(o_supply_warn),
      .o_tune_port_en(o_tune_port_en), .o_tune_valid(o_tune_valid),
      .o_tune_data(o_tune_data), .o_tune_good(o_tune_good),
      .o_tune_bad(o_tune_bad), .o_tune_reject(o_tune_reject),
      .o_mon_status(o_mon_status));
   sss_io_model sss_io_model_i (.i_clock(i_clock), .i_rstn(i_rstn),
      .i_kick_en(kick_en), .o_wd_kick(i_wd_kick));
   // Half period of 12.5 ns gives 40 MHz.
   always #12.5 i_clock = ~i_clock;
   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   // Inputs change 1 ns after an edge, so sampling never races.
   task automatic step();
      @(posedge i_clock);
      #1;
   endtask : step
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   function automatic logic [31:0] lfsr(input logic [31:0] r);
      return {r[30:0], 1'b0} ^ (r[31] ? 32'h04c11db7 : 32'h0);
   endfunction : lfsr
   function automatic logic [7:0] crc8(input logic [7:0] v);
      logic [7:0] c;
      c = v;
      for (int i = 0; i < 8; i++)
         c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
      return c;
   endfunction : crc8
   // The trailing idle cycle keeps two strobes off one time step.
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      i_addr <= a;
      i_re <= 1'b1;
      step();
      i_re <= 1'b0;
      v = o_rdata;
      step();
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      i_addr <= a;
      i_wdata <= v;
      i_we <= 1'b1;
      step();
      i_we <= 1'b0;
      step();
   endtask : wr
   task automatic rel();
      i_release <= 1'b1;
      step();
      i_release <= 1'b0;
      repeat (2) step();
   endtask : rel
   task automatic tsend(input logic [7:0] v, input logic l);
      i_tune_valid <= 1'b1;
      i_tune_data <= v;
      i_tune_last <= l;
      step();
   endtask : tsend
   task automatic wait_safe(input int n);
      for (int k = 0; k < n && o_safe !== 1'b1; k++)
         step();
   endtask : wait_safe
   // Field outputs follow the application only in run.
   task automatic outs();
      chk(o_safe, exp_run == 0);
      chk(o_do_energize, exp_run ? i_app_do : 8'h00);
      chk(o_ao_value, exp_run ? i_app_ao : 32'h0);
   endtask : outs
   task automatic cause(input int c, input logic v);
      case (c)
         0: i_fault_class1 <= v;
         1: i_fault_class2 <= v;
         2: i_diag_safe_demand <= v;
         3: i_override_key <= v;
         4: i_supply_ok <= v ? 2'b00 : 2'b11;
         5: kick_en <= !v;
         default: wr(`SSS_ADDR_CTRL, {31'h0, v});
      endcase
   endtask : cause
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude
   // -------------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------------
   // Watchdog: the whole sequence needs about 300 cycles.
   initial begin
      #150us;
      miscompares++;
      conclude();
   end
   // Main sequence, each stage checked against the bench's own model.
   initial begin
      repeat (16) @(posedge i_clock);
      i_rstn <= 1'b1;
      repeat (3) step();
      chk(o_safe, 1'b1);
      chk(o_mon_status[2:0], 3'b001);
      rd(`SSS_ADDR_CTRL, d);
      chk(d, 32'h0);
      rd(8'h10, d);
      chk(d, 32'h0);
      i_selftest_done <= 1'b1;
      i_selftest_pass <= 1'b1;
      rel();
      chk(o_mon_status[2:0], 3'b001);
      i_config_ok <= 1'b1;
      rel();
      chk(o_mon_status[2:0], 3'b001);
      i_module_type_ok <= 4'hf;
      repeat (2) step();
      chk(o_mon_status[2:0], 3'b010);
      rel();
      exp_run = 1;
      outs();
      $display("test startup done");
      for (int k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         {i_di_raw, i_di_fault, i_app_do, i_ai_fault} <= seed[27:0];
         i_ai_raw <= {seed, ~seed};
         i_app_ao <= ~seed;
         repeat (2) step();
         chk(o_di_value, i_di_raw & ~i_di_fault);
         for (int ch = 0; ch < 4; ch++)
            chk(o_ai_value[ch*16+:16],
               i_ai_fault[ch] ? 16'h0 : i_ai_raw[ch*16+:16]);
         outs();
      end
      $display("test inputs done");
      for (int c = 0; c < 7; c++) begin
         cause(c, 1'b1);
         wait_safe(WDC + 20);
         exp_run = 0;
         outs();
         if (c == 5) begin
            // The four watchdogs expire up to seven cycles apart.
            repeat (8) step();
            rd(`SSS_ADDR_STATUS, d);
            chk(d[11:8], 4'hf);
         end
         rel();
         chk(o_safe, 1'b1);
         // Release rises while the cause still stands, so only a hold remains.
         i_release <= 1'b1;
         step();
         cause(c, 1'b0);
         repeat (12) step();
         chk(o_safe, 1'b1);
         chk(o_mon_status[2:0], 3'b010);
         i_release <= 1'b0;
         step();
         rel();
         exp_run = 1;
         outs();
      end
      $display("test trips done");
      i_supply_ok <= 2'b01;
      repeat (3) step();
      outs();
      chk(o_supply_warn, 1'b1);
      i_supply_ok <= 2'b11;
      rd(`SSS_ADDR_STATUS, d);
      chk(d[3], 1'b1);
      wr(`SSS_ADDR_STATUS, 32'h8);
      rd(`SSS_ADDR_STATUS, d);
      chk(d[3:0], 4'h4);
      $display("test supply done");
      i_tune_key <= 1'b1;
      wait_safe(10);
      exp_run = 0;
      outs();
      step();
      chk(o_tune_port_en, 1'b1);
      chk(o_mon_status[5], 1'b1);
      for (int k = 0; k < 2; k++) begin
         seed = lfsr(seed);
         b = seed[7:0];
         tsend(b, 1'b0);
         chk(o_tune_valid, 1'b1);
         chk(o_tune_data, b);
         tsend(crc8(b) ^ 8'(k), 1'b1);
         chk(o_tune_good, k == 0);
         chk(o_tune_bad, k == 1);
      end
      i_tune_valid <= 1'b0;
      i_tune_key <= 1'b0;
      repeat (2) step();
      chk(o_tune_port_en, 1'b0);
      tsend(8'h5a, 1'b0);
      chk(o_tune_reject, 1'b1);
      chk(o_tune_valid, 1'b0);
      i_tune_valid <= 1'b0;
      step();
      rel();
      exp_run = 1;
      outs();
      $display("test tuning done");
      conclude();
   end
endmodule : tb_top
